// [inc/az_duty_pkg.sv]
// Frame layout, message selectors, field positions and widths of the calibration and duty messages.
`default_nettype none
package az_duty_pkg;
  // Channel count and frame shape.
  localparam int N_CH = 8;
  localparam int CH_W = 3;
  localparam int FRAME_W = 32;
  localparam int BITCNT_W = 5;
  localparam int RW_BIT = 31;
  localparam int SEL_HI = 30;
  localparam int SEL_LO = 27;
  localparam int CHANNEL_SELECT_HI = 26;
  localparam int CHANNEL_SELECT_LO = 24;
  localparam int SEL_W = 4;
  // Message selectors served here.
  localparam logic [3:0] SEL_CAL = 4'h7;
  localparam logic [3:0] SEL_DUTY = 4'h8;
  // Calibration response fields.
  localparam int ON_DONE_BIT = 17;
  localparam int OFF_DONE_BIT = 16;
  localparam int ON_VAL_LO = 8;
  localparam int OFF_VAL_LO = 0;
  localparam int OFFS_W = 8;
  // One offset count is full scale over 2048 steps, divided by Rsense.
  localparam int SENSE_FS_MV = 320;
  localparam int OFFS_STEPS = 2048;
  // Duty fields and reset values.
  localparam int DUTY_W = 19;
  localparam int RB_W = 21;
  localparam int RB_ZERO_LO = 11;
  localparam int RB_ZERO_HI = 12;
  localparam logic [18:0] DUTY_RST = 19'h00000;
  localparam logic [31:0] RESP_RST = 32'h00000000;
  localparam logic CAL_FLAG_RST = 1'b0;
  // Direct mode period is the divider times 32, a shift by five.
  localparam int DIRECT_SH = 5;
  localparam int NM_DEF_W = 10;
  localparam logic MODE_DIRECT = 1'b1;
endpackage : az_duty_pkg
`default_nettype wire

// [design/spi_link_port.sv]
// Serial link end on the link clock: frame capture and response shift-out.
`timescale 1ns/1ps
`default_nettype none
module spi_link_port
  import az_duty_pkg::*;
(
  // Link pins.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Towards the system clock side.
  output logic [31:0] frame_word,
  output logic frame_done,
  input wire logic [31:0] resp_word
);
  typedef struct packed {
    logic [BITCNT_W-1:0] cnt;
    logic [30:0] shift;
  } link_type;

  link_type lk_ff;
  logic done_ff;

  // Deselect clears the frame state; the clock stands still then.
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      lk_ff <= '0;
    end
    else
    begin
      lk_ff.shift <= {lk_ff.shift[29:0], mosi};
      lk_ff.cnt <= lk_ff.cnt + 1'b1;
    end
  end

  // Deselect must not clear the done flag: it has to outlive the select
  // edge long enough to cross. It drops at the first clock of the next
  // frame, or at a 33rd clock, so short frames and long ones not a multiple of 32 clocks are refused.
  always_ff @(posedge sclk)
  begin
    done_ff <= (lk_ff.cnt == 5'h1F);
  end

  // The word survives deselect so the other domain can read it at leisure.
  always_ff @(posedge sclk)
  begin
    if (!cs_n && lk_ff.cnt == 5'h1F)
    begin
      frame_word <= {lk_ff.shift, mosi};
    end
  end

  // Bit 31 of every answer is zero, so the idle level serves as first bit.
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      miso <= 1'b0;
    end
    else
    begin
      miso <= (lk_ff.cnt == '0) ? 1'b0 : resp_word[5'h1F - lk_ff.cnt];
    end
  end

  assign frame_done = done_ff;
endmodule : spi_link_port
`default_nettype wire

// [design/duty_pwm_channel.sv]
// One channel's gate generator in direct PWM or current control mode.
`timescale 1ns/1ps
`default_nettype none
module duty_pwm_channel
  import az_duty_pkg::*;
#(
  parameter int DIV_W = NM_DEF_W,
  parameter int SMP_W = NM_DEF_W
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Mode, period and duty sources.
  input wire logic mode_direct,
  input wire logic [DIV_W-1:0] period_div,
  input wire logic [SMP_W-1:0] sample_count,
  input wire logic [DUTY_W-1:0] duty_direct,
  input wire logic [RB_W-1:0] duty_pi,
  // Gate.
  output logic gate_drive
);
  localparam int P_W = DIV_W + ((SMP_W > DIRECT_SH) ? SMP_W : DIRECT_SH);

  if (DIV_W < 1 || SMP_W < 1 || P_W > 31)
  begin : g_bad_width
    $error("duty_pwm_channel: divider or sample widths unsupported");
  end

  typedef struct packed {
    logic [P_W-1:0] cnt;
    logic gate;
  } pwm_type;

  pwm_type st_ff, nxt_st;
  logic [31:0] period_w;
  logic [31:0] on_w;

  // Period and on time in clock ticks; in current control mode the stored duty waits unused.
  always_comb
  begin
    period_w = mode_direct ? (32'(period_div) << DIRECT_SH)
                           : (32'(period_div) * 32'(sample_count));
    on_w = mode_direct ? 32'(duty_direct) : 32'(duty_pi);
    nxt_st = st_ff;
    if (period_w == '0 || 32'(st_ff.cnt) + 32'h1 >= period_w)
    begin
      nxt_st.cnt = '0;
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + P_W'(1);
    end
    // An on time past the period keeps the gate on throughout.
    nxt_st.gate = (period_w != '0) && (on_w > 32'(st_ff.cnt));
  end

  // State register.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign gate_drive = st_ff.gate;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sat_full_on_a: assert property (
    (period_w != '0 && on_w >= period_w)[*3] |=> gate_drive)
    else $error("saturated duty did not hold the gate on");
  period_wrap_a: assert property (
    (mode_direct && period_w != '0 && 32'(st_ff.cnt) == period_w - 32'h1)
      |=> st_ff.cnt == '0)
    else $error("direct period did not wrap at 32 times the divider");
endmodule : duty_pwm_channel
`default_nettype wire

// [design/autozero_and_duty_messages.sv]
// Calibration trigger and duty message handling for eight channels.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Frame: write flag, selector, channel; 0111 calibrates.
// - Selector 1000 addresses duty setting and readback.
// - Calibration write starts sequence, clears done flags.
// - Finished sequence sets both done flags.
// - Calibration read clears flags, starts nothing.
// - Done flags in bits 17, 16; read-clear.
// - Gate-on offset 15:8, gate-off offset 7:0.
// - Offset count is 320 mV over 2048.
// - Duty write stores 19 bits; direct mode uses.
// - Duty written in current mode waits unused.
// - Duty readback is 21 bits, resets zero.
// - Current mode readback shows regulator duty.
// - Direct readback shows stored duty, bits 12:11 zero.
// - Current mode fraction is readback over N*M.
// - Direct fraction is duty over 32 times N.
// - Duty beyond full period saturates fully on.
module autozero_and_duty_messages
  import az_duty_pkg::*;
#(
  parameter int DIV_W = az_duty_pkg::NM_DEF_W,
  parameter int SMP_W = az_duty_pkg::NM_DEF_W
)
(
  // System clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial link from the host.
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Control mode and regulator duty per channel.
  input wire logic [az_duty_pkg::N_CH-1:0] ctrl_mode_direct,
  input wire logic [az_duty_pkg::N_CH-1:0][DIV_W-1:0] period_div,
  input wire logic [az_duty_pkg::N_CH-1:0][SMP_W-1:0] sample_count,
  input wire logic [az_duty_pkg::N_CH-1:0][az_duty_pkg::RB_W-1:0] pi_duty,
  // Calibration sequence engine.
  output logic [az_duty_pkg::N_CH-1:0] az_start,
  input wire logic [az_duty_pkg::N_CH-1:0] az_seq_done,
  input wire logic [az_duty_pkg::N_CH-1:0][az_duty_pkg::OFFS_W-1:0]
    gate_on_offset_value,
  input wire logic [az_duty_pkg::N_CH-1:0][az_duty_pkg::OFFS_W-1:0]
    gate_off_offset_value,
  // Gate outputs.
  output logic [az_duty_pkg::N_CH-1:0] gate_drive
);
  import az_duty_pkg::*;

  if (DIV_W < 1 || SMP_W < 1 || DIV_W + SMP_W > 30)
  begin : g_bad_param
    $error("autozero_and_duty_messages: divider or sample width unsupported");
  end

  // All system clock state of the block.
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] done_sync;
    logic cs_prev;
    logic armed;
    logic [N_CH-1:0] gate_on_cal_done;
    logic [N_CH-1:0] gate_off_cal_done;
    logic [N_CH-1:0] az_start;
    logic [N_CH-1:0][DUTY_W-1:0] duty;
    logic [FRAME_W-1:0] resp;
  } state_type;

  state_type st_ff, nxt_st;

  logic [FRAME_W-1:0] link_word;
  logic link_done;
  logic cmd_go;
  logic is_write;
  logic [SEL_W-1:0] message_selector;
  logic [CH_W-1:0] channel_select;
  logic [N_CH-1:0] ch_onehot;

  // The link end shifts frames on the host clock. Its word is held still
  // from the last clock of a frame until the next frame begins, so this
  // side may read it once the done flag has crossed.
  spi_link_port u_link (
    .sclk (spi_sclk),
    .cs_n (spi_cs_n),
    .mosi (spi_mosi),
    .miso (spi_miso),
    .frame_word (link_word),
    .frame_done (link_done),
    .resp_word (st_ff.resp)
  );

  // A frame counts only when the select rises after all 32 bits arrived.
  // A short frame is dropped whole, which keeps a glitch on the select
  // from writing a duty value built of half a frame. The armed bit keeps
  // a select pulse with no clock at all from replaying the last frame,
  // whose done flag still stands on the link side.
  assign cmd_go = st_ff.cs_sync[1] && !st_ff.cs_prev && st_ff.done_sync[1] &&
    st_ff.armed;

  // Header fields.
  assign is_write = link_word[RW_BIT];
  assign message_selector = link_word[SEL_HI:SEL_LO];
  assign channel_select = link_word[CHANNEL_SELECT_HI:CHANNEL_SELECT_LO];
  assign ch_onehot = N_CH'(1) << channel_select;

  // Duty readback: regulator output in current mode, stored value otherwise.
  function automatic logic [RB_W-1:0] duty_readback(
    input logic direct,
    input logic [DUTY_W-1:0] stored,
    input logic [RB_W-1:0] regulated
  );
    logic [RB_W-1:0] rb;
    rb = RB_W'(stored);
    rb[RB_ZERO_HI:RB_ZERO_LO] = 2'b00;
    if (direct != MODE_DIRECT)
    begin
      rb = regulated;
    end
    return rb;
  endfunction : duty_readback

  // Calibration answer: done flags above the two offset values.
  function automatic logic [23:0] cal_answer(
    input logic on_done,
    input logic off_done,
    input logic [OFFS_W-1:0] on_val,
    input logic [OFFS_W-1:0] off_val
  );
    logic [23:0] a;
    a = '0;
    a[ON_DONE_BIT] = on_done;
    a[OFF_DONE_BIT] = off_done;
    // Offsets pass raw; one count is the sense full scale over 2048.
    a[ON_VAL_LO +: OFFS_W] = on_val;
    a[OFF_VAL_LO +: OFFS_W] = off_val;
    return a;
  endfunction : cal_answer

  // Next state. Flags are cleared by the frame first and then set by the
  // engine, so a sequence that ends in the clearing cycle is still seen.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.cs_sync = {st_ff.cs_sync[0], spi_cs_n};
    nxt_st.done_sync = {st_ff.done_sync[0], link_done};
    nxt_st.cs_prev = st_ff.cs_sync[1];
    // Arm again only once the done flag was seen low in a new frame.
    nxt_st.armed = (st_ff.armed && !cmd_go) || !st_ff.done_sync[1];
    nxt_st.az_start = '0;
    if (cmd_go)
    begin
      case (message_selector)
        SEL_CAL:
        begin
          // Both reading and writing clear the channel's flags.
          nxt_st.gate_on_cal_done[channel_select] = 1'b0;
          nxt_st.gate_off_cal_done[channel_select] = 1'b0;
          nxt_st.az_start[channel_select] = is_write;
          nxt_st.resp = {1'b0, message_selector, channel_select,
            cal_answer(st_ff.gate_on_cal_done[channel_select],
                       st_ff.gate_off_cal_done[channel_select],
                       gate_on_offset_value[channel_select],
                       gate_off_offset_value[channel_select])};
        end
        SEL_DUTY:
        begin
          if (is_write)
          begin
            nxt_st.duty[channel_select] = link_word[DUTY_W-1:0];
          end
          nxt_st.resp = {1'b0, message_selector, channel_select, 3'h0,
            duty_readback(ctrl_mode_direct[channel_select],
                          st_ff.duty[channel_select],
                          pi_duty[channel_select])};
        end
        default:
        begin
          // Other messages belong elsewhere; only the header is echoed.
          nxt_st.resp = {1'b0, message_selector, channel_select, 24'h000000};
        end
      endcase
    end
    nxt_st.gate_on_cal_done = nxt_st.gate_on_cal_done | az_seq_done;
    nxt_st.gate_off_cal_done = nxt_st.gate_off_cal_done | az_seq_done;
  end

  // State register with synchronous reset to documented values.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_ff.cs_sync <= 2'b11;
      st_ff.done_sync <= 2'b00;
      st_ff.cs_prev <= 1'b1;
      st_ff.armed <= 1'b0;
      st_ff.gate_on_cal_done <= {N_CH{CAL_FLAG_RST}};
      st_ff.gate_off_cal_done <= {N_CH{CAL_FLAG_RST}};
      st_ff.az_start <= '0;
      st_ff.duty <= {N_CH{DUTY_RST}};
      st_ff.resp <= RESP_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign az_start = st_ff.az_start;

  // One gate generator per channel, each fed from its own stored duty in direct mode, its regulator duty otherwise.
  for (genvar i = 0; i < N_CH; i++)
  begin : g_ch
    duty_pwm_channel #(
      .DIV_W (DIV_W),
      .SMP_W (SMP_W)
    ) u_pwm (
      .mclk (mclk),
      .sys_rst (sys_rst),
      .mode_direct (ctrl_mode_direct[i]),
      .period_div (period_div[i]),
      .sample_count (sample_count[i]),
      .duty_direct (st_ff.duty[i]),
      .duty_pi (pi_duty[i]),
      .gate_drive (gate_drive[i])
    );
  end

  // Checks on the message handling.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence cal_write_s;
    cmd_go && message_selector == SEL_CAL && is_write;
  endsequence

  sequence cal_read_s;
    cmd_go && message_selector == SEL_CAL && !is_write;
  endsequence

  sequence start_pulse_s;
    (az_start == $past(ch_onehot)) ##1 (az_start == '0);
  endsequence

  cal_write_start_a: assert property (
    cal_write_s |=> start_pulse_s)
    else $error("calibration write did not pulse the channel start once");
  cal_read_idle_a: assert property (
    cal_read_s |=> az_start == '0)
    else $error("calibration read started a sequence");
  cal_flag_clear_a: assert property (
    (cal_read_s or cal_write_s) |=>
      ((st_ff.gate_on_cal_done & $past(ch_onehot)) ==
       ($past(az_seq_done) & $past(ch_onehot))) &&
      ((st_ff.gate_off_cal_done & $past(ch_onehot)) ==
       ($past(az_seq_done) & $past(ch_onehot))))
    else $error("calibration access did not clear the done flags");
  cal_flag_set_a: assert property (
    (|az_seq_done) |=>
      ((st_ff.gate_on_cal_done & st_ff.gate_off_cal_done &
        $past(az_seq_done)) == $past(az_seq_done)))
    else $error("finished sequence did not set both done flags");
  cal_answer_a: assert property (
    cal_read_s |=>
      st_ff.resp[ON_DONE_BIT] ==
        $past(st_ff.gate_on_cal_done[channel_select]) &&
      st_ff.resp[OFF_DONE_BIT] ==
        $past(st_ff.gate_off_cal_done[channel_select]) &&
      st_ff.resp[SEL_HI:SEL_LO] == SEL_CAL)
    else $error("calibration answer flags wrong");
  cal_offsets_a: assert property (
    cal_read_s |=>
      st_ff.resp[ON_VAL_LO +: OFFS_W] ==
        $past(gate_on_offset_value[channel_select]) &&
      st_ff.resp[OFF_VAL_LO +: OFFS_W] ==
        $past(gate_off_offset_value[channel_select]))
    else $error("calibration answer offsets wrong");
  duty_store_a: assert property (
    (cmd_go && message_selector == SEL_DUTY && is_write) |=>
      st_ff.duty[$past(channel_select)] == $past(link_word[DUTY_W-1:0]))
    else $error("duty write not stored");
  duty_hold_a: assert property (
    !cmd_go |=> $stable(st_ff.duty))
    else $error("stored duty changed without a write");
  duty_pi_rb_a: assert property (
    (cmd_go && message_selector == SEL_DUTY &&
     ctrl_mode_direct[channel_select] != MODE_DIRECT) |=>
      st_ff.resp[RB_W-1:0] == $past(pi_duty[channel_select]))
    else $error("current mode readback is not the regulator duty");
  duty_direct_rb_a: assert property (
    (cmd_go && message_selector == SEL_DUTY &&
     ctrl_mode_direct[channel_select] == MODE_DIRECT) |=>
      st_ff.resp[RB_ZERO_HI:RB_ZERO_LO] == 2'b00 &&
      st_ff.resp[RB_ZERO_LO-1:0] ==
        $past(st_ff.duty[channel_select][RB_ZERO_LO-1:0]) &&
      st_ff.resp[RB_W-1:RB_ZERO_HI+1] ==
        RB_W'($past(st_ff.duty[channel_select][DUTY_W-1:RB_ZERO_HI+1])))
    else $error("direct mode readback wrong");

  // Frame level checks: header echo, start cause, flag scope and reset.
  // Reset is checked with the default disable switched off on purpose.
  sequence any_cal_s;
    cmd_go && message_selector == SEL_CAL;
  endsequence

  sequence in_reset_s;
    sys_rst ##1 sys_rst;
  endsequence

  answer_head_a: assert property (
    cmd_go |=>
      st_ff.resp[FRAME_W-1:CHANNEL_SELECT_LO] ==
        {1'b0, $past(message_selector), $past(channel_select)})
    else $error("answer header does not echo selector and channel");
  start_cause_a: assert property (
    (|az_start) |->
      $past(cmd_go && message_selector == SEL_CAL && is_write))
    else $error("sequence started without a calibration write");
  flag_keep_a: assert property (
    (!cmd_go && az_seq_done == '0) |=>
      $stable(st_ff.gate_on_cal_done) && $stable(st_ff.gate_off_cal_done))
    else $error("done flags changed with no access and no finish");
  other_ch_flags_a: assert property (
    any_cal_s |=>
      (((st_ff.gate_on_cal_done ^ $past(st_ff.gate_on_cal_done)) |
        (st_ff.gate_off_cal_done ^ $past(st_ff.gate_off_cal_done))) &
       ~$past(ch_onehot) & ~$past(az_seq_done)) == '0)
    else $error("calibration access touched another channel flags");
  unknown_sel_a: assert property (
    (cmd_go && message_selector != SEL_CAL && message_selector != SEL_DUTY)
      |=> st_ff.resp[CHANNEL_SELECT_LO-1:0] == 24'h000000 && az_start == '0)
    else $error("unknown selector changed more than the echo");
  reset_values_a: assert property (
    disable iff (1'b0) in_reset_s |->
      st_ff.duty == '0 && st_ff.resp == RESP_RST && az_start == '0 &&
      gate_drive == '0 && st_ff.gate_on_cal_done == '0 &&
      st_ff.gate_off_cal_done == '0)
    else $error("reset did not clear duty, answer, flags and gates");
endmodule : autozero_and_duty_messages
`default_nettype wire

// [tb/host_spi_model.sv]
// Host side serial master model that sends and receives one frame per call.
`timescale 1ns/1ps
`default_nettype none
module host_spi_model
(
  // Link pins.
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // Idle: deselected, clock parked low.
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Full-duplex 32-bit frame, MSB first, 12 ns link period.
  // The clock only toggles inside the frame, as a real master does.
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    int k;
    #3.7;
    cs_n = 1'b0;
    for (k = 31; k >= 0; k--)
    begin
      mosi = tx[k];
      #6;
      sclk = 1'b1;
      rx[k] = miso;
      #6;
      sclk = 1'b0;
    end
    // Released data line flips so a stale bit is never mistaken for data.
    mosi = ~mosi;
    #6;
    cs_n = 1'b1;
    // Gap covers the deselect minimum and the device's apply latency.
    #400;
  endtask : xfer
endmodule : host_spi_model
`default_nettype wire

// [tb/tb_autozero_and_duty_messages.sv]
// Testbench for the calibration trigger and duty message block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_autozero_and_duty_messages;
  import az_duty_pkg::*;
  logic mclk;
  logic sys_rst;
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_mosi;
  logic spi_miso;
  logic [N_CH-1:0] mode;
  logic [N_CH-1:0][9:0] ndiv;
  logic [N_CH-1:0][9:0] mcnt;
  logic [N_CH-1:0][RB_W-1:0] pid;
  logic [N_CH-1:0] az_start;
  logic [N_CH-1:0] az_done;
  logic [N_CH-1:0][OFFS_W-1:0] onv;
  logic [N_CH-1:0][OFFS_W-1:0] offv;
  logic [N_CH-1:0] gate;
  logic [31:0] rx;
  int az_cnt[N_CH];
  int n_mismatch;
  int tests_run;
  int n;

  autozero_and_duty_messages u_autozero_and_duty_messages (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .ctrl_mode_direct(mode),
    .period_div(ndiv),
    .sample_count(mcnt),
    .pi_duty(pid),
    .az_start(az_start),
    .az_seq_done(az_done),
    .gate_on_offset_value(onv),
    .gate_off_offset_value(offv),
    .gate_drive(gate)
  );

  host_spi_model u_host_spi_model (
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi),
    .miso(spi_miso)
  );

  // System clock, 25 ns period.
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // Counting start pulses also catches a pulse that lasts too long.
  always @(posedge mclk)
  begin
    for (int i = 0; i < N_CH; i++)
      if (az_start[i] === 1'b1)
        az_cnt[i]++;
  end

  // Sends a command, then a neutral read that collects its answer.
  task automatic cmd(input logic [31:0] tx, output logic [31:0] ans);
    logic [31:0] skip;
    u_host_spi_model.xfer(tx, skip);
    u_host_spi_model.xfer(32'h00000000, ans);
  endtask : cmd

  // Expected calibration answer for one channel and flag pair.
  function automatic logic [31:0] cal_ans(input logic [2:0] ch,
                                          input logic [1:0] f);
    return {1'b0, SEL_CAL, ch, 6'h00, f, onv[ch], offv[ch]};
  endfunction : cal_ans

  // One-cycle sequence-finished pulse on one channel.
  task automatic seq_done(input int ch);
    @(posedge mclk);
    az_done[ch] <= 1'b1;
    @(posedge mclk);
    az_done <= 8'h00;
  endtask : seq_done

  // Counts gate high cycles over a window of p cycles.
  task automatic gate_high(input int ch, input int p, output int cnt);
    cnt = 0;
    repeat (p)
    begin
      @(posedge mclk);
      #1;
      if (gate[ch] === 1'b1)
        cnt++;
    end
  endtask : gate_high

  task automatic print_verdict;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Watchdog: the whole sequence needs roughly 25 us.
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    sys_rst = 1'b1;
    mode = 8'h40;
    ndiv = '0;
    mcnt = '0;
    pid = '0;
    az_done = 8'h00;
    for (int i = 0; i < N_CH; i++)
    begin
      onv[i] = 8'h10 * i[7:0] + 8'h05;
      offv[i] = 8'hF0 - i[7:0];
    end
    ndiv[1] = 10'h003;
    mcnt[1] = 10'h004;
    pid[1] = 21'h000005;
    ndiv[2] = 10'h002;
    pid[2] = 21'h012345;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    `CHK("gate in reset", 8'h00, gate)
    repeat (5) @(posedge mclk);
    cmd({1'b0, SEL_CAL, 3'd0, 24'h0}, rx);
    `CHK("cal flags after reset", cal_ans(3'd0, 2'b00), rx)
    cmd({1'b0, SEL_DUTY, 3'd6, 24'h0}, rx);
    `CHK("duty after reset", {1'b0, SEL_DUTY, 3'd6, 24'h0}, rx)
    $display("test reset values done");

    // Channel three gate is idle, so no freewheel current remains.
    cmd({1'b1, SEL_CAL, 3'd3, 24'h0}, rx);
    `CHK("cal write answer", cal_ans(3'd3, 2'b00), rx)
    `CHK("start pulses ch3", 1, az_cnt[3])
    `CHK("start pulses ch5", 0, az_cnt[5])
    seq_done(3);
    cmd({1'b0, SEL_CAL, 3'd3, 24'h0}, rx);
    `CHK("cal done read", cal_ans(3'd3, 2'b11), rx)
    `CHK("read starts nothing", 1, az_cnt[3])
    cmd({1'b0, SEL_CAL, 3'd3, 24'h0}, rx);
    `CHK("cal flags cleared", cal_ans(3'd3, 2'b00), rx)
    seq_done(3);
    cmd({1'b0, SEL_CAL, 3'd5, 24'h0}, rx);
    `CHK("other channel flags", cal_ans(3'd5, 2'b00), rx)
    cmd({1'b1, SEL_CAL, 3'd3, 24'h0}, rx);
    `CHK("write shows old flags", cal_ans(3'd3, 2'b11), rx)
    cmd({1'b0, SEL_CAL, 3'd3, 24'h0}, rx);
    `CHK("write cleared flags", cal_ans(3'd3, 2'b00), rx)
    `CHK("second start pulse", 2, az_cnt[3])
    $display("test calibration done");

    // Bits 12 and 11 are set on purpose to see them masked later.
    cmd({1'b1, SEL_DUTY, 3'd2, 5'h00, 19'h1B8F5}, rx);
    cmd({1'b0, SEL_DUTY, 3'd2, 24'h0}, rx);
    `CHK("current mode rb", {1'b0, SEL_DUTY, 3'd2, 3'h0, pid[2]}, rx)
    @(posedge mclk);
    mode[2] <= 1'b1;
    cmd({1'b0, SEL_DUTY, 3'd2, 24'h0}, rx);
    `CHK("direct mode rb", {1'b0, SEL_DUTY, 3'd2, 3'h0, 21'h01A0F5}, rx)
    cmd({1'b0, SEL_DUTY, 3'd6, 24'h0}, rx);
    `CHK("duty per channel", {1'b0, SEL_DUTY, 3'd6, 24'h0}, rx)
    $display("test duty readback done");

    // Channel two: period is 2 times 32 cycles.
    gate_high(2, 64, n);
    `CHK("saturated gate", 64, n)
    cmd({1'b1, SEL_DUTY, 3'd2, 5'h00, 19'h00014}, rx);
    gate_high(2, 64, n);
    `CHK("direct gate", 20, n)
    // Channel one: period is 3 times 4 cycles.
    gate_high(1, 12, n);
    `CHK("current gate", 5, n)
    $display("test gate done");
    print_verdict();
  end
endmodule : tb_autozero_and_duty_messages
`default_nettype wire
